// >>> rtl/mba_pkg.sv
// constants, field layouts and carrier types of the motor brake / auto-configuration block
package mba_pkg;
   // parameter indices on the host parameter port
   localparam logic [15:0] IDX_AUTO_CFG   = 16'h3451;  // auto_config_enable
   localparam logic [15:0] IDX_BRAKE      = 16'h3587;  // brake_present
   localparam logic [15:0] IDX_COIL_TC    = 16'h3454;  // coil_thermal_constant
   localparam logic [15:0] IDX_CONT_CUR   = 16'h358e;  // continuous_current
   localparam logic [15:0] IDX_MEM_BASE   = 16'h3600;  // base + slot for other motor words
   localparam logic [15:0] IDX_LOAD_INER  = 16'h3700;  // load_inertia, float
   localparam logic [15:0] IDX_BRAKE_IMM  = 16'h3701;  // brake_on_disable_immediate
   localparam logic [15:0] IDX_VTHRESH    = 16'h3702;  // standstill_velocity_threshold
   localparam logic [15:0] IDX_DWELL      = 16'h3703;  // standstill_dwell_time, ms
   localparam logic [15:0] IDX_STATUS     = 16'h3704;  // read-only brake status
   localparam logic [15:0] IDX_FAULT_CLR  = 16'h3705;  // write ones to clear faults

   // motor parameter slots that motor memory may fill
   localparam int          NSLOT          = 17;
   localparam logic [4:0]  SLOT_BRAKE     = 5'h00;     // brake_present
   localparam logic [4:0]  SLOT_COIL_TC   = 5'h01;
   localparam logic [4:0]  SLOT_CONT_CUR  = 5'h02;
   localparam logic [4:0]  SLOT_EXT_FIRST = 5'h0b;     // phase, apply time, vel, voltage
   localparam logic [4:0]  SLOT_FW_FIRST  = 5'h0f;     // sensor type, overtemp level
   localparam logic [4:0]  SLOT_LAST      = 5'h10;

   // feedback memory version in hundredths; 0.01 reads as 1
   localparam logic [15:0] MEMVER_MIN     = 16'h0001;
   // firmware version from which sensor type and overtemp level are filled
   localparam logic [31:0] FW_TEMP_MIN    = 32'h0109_0000;

   // load inertia bounds as single-precision bit patterns (1.0 and 1e6)
   localparam logic [31:0] INER_MIN       = 32'h3f80_0000;
   localparam logic [31:0] INER_MAX       = 32'h4974_2400;

   // reset values
   localparam logic [31:0] RST_WORD       = 32'h0000_0000;
   localparam logic [15:0] RST_DWELL      = 16'h0000;

   // status word layout
   localparam int          ST_F_OPEN      = 0;
   localparam int          ST_F_SHORT     = 1;
   localparam int          ST_F_ABSENT    = 2;
   localparam int          ST_RELEASE     = 4;

   // timing
   localparam int          CLK_NS         = 50;
   localparam int          MS_NS          = 1000000;
   localparam int          POLL_MS        = 16;
   localparam int          CNT_W          = 24;
   localparam int          MS_CYC         = MS_NS / CLK_NS;
   localparam int          POLL_CYC       = (POLL_MS * MS_NS) / CLK_NS;

   // host parameter request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] idx;
      logic [31:0] wdata;
   } mba_req_t;

   // host parameter answer
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } mba_rsp_t;

   // identification word from the feedback memory reader
   typedef struct packed {
      logic        valid;
      logic [4:0]  slot;
      logic [31:0] data;
      logic [15:0] version;
   } mba_mem_t;

   // brake circuit pins
   typedef struct packed {
      logic        open_ckt;
      logic        short_ckt;
      logic        connected;
   } mba_brk_pin_t;

   // brake sequencer states, one-hot
   typedef enum logic [2:0] {
      BS_RUN  = 3'b001,
      BS_WAIT = 3'b010,
      BS_HELD = 3'b100
   } mba_bstate_t;

   // whole state of the block
   typedef struct packed {
      mba_rsp_t                     rsp;
      logic                         auto_cfg;
      logic                         brake_imm;
      logic [31:0]                  vthresh;
      logic [15:0]                  dwell;
      logic [31:0]                  load_iner;
      logic [NSLOT-1:0][31:0]       prm;
      logic [NSLOT-1:0]             loaded;
      logic [2:0]                   fault;
      mba_brk_pin_t                 sync1;
      mba_brk_pin_t                 sync2;
      logic [CNT_W-1:0]             poll_cnt;
      logic [CNT_W-1:0]             ms_cnt;
      logic [15:0]                  dwell_cnt;
      mba_bstate_t                  bst;
      logic                         release_brk;
   } mba_state_t;
endpackage : mba_pkg

// >>> rtl/mba_top.sv
// motor auto-configuration, parameter protection and brake supervision
// Overview of operation
// - auto set: motor words come from feedback memory
// - auto set: memory-filled parameters refuse writes
// - auto clear: nothing loaded, host writes parameters
// - parameters not memory-filled always stay writable
// - base motor set filled under auto mode
// - memory version above 0.01 adds four more
// - newer firmware adds sensor type, overtemp level
// - brake presence never drives the brake output
// - brake present: check open and short indications
// - brake absent: ignore circuit, raise no fault
// - brake present but unconnected raises a fault
// - brake circuit sampled once every 16 ms
// - normal disable: brake after standstill dwell
// - immediate mode: brake at once on disable
// - load inertia float, range 1 to 1e6
`timescale 1ns/100ps
module mba_top #(
   parameter logic [mba_pkg::CNT_W-1:0] POLL_CYCLES = mba_pkg::CNT_W'(mba_pkg::POLL_CYC),
   parameter logic [mba_pkg::CNT_W-1:0] MS_CYCLES   = mba_pkg::CNT_W'(mba_pkg::MS_CYC),
   parameter logic [31:0]               FW_VERSION  = mba_pkg::FW_TEMP_MIN
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   // host parameter port
   input  wire mba_pkg::mba_req_t     host_req,
   output      mba_pkg::mba_rsp_t     host_rsp,
   // feedback memory reader
   input  wire mba_pkg::mba_mem_t     mem_word,
   // drive state
   input  wire logic                  drive_enable,
   input  wire logic [31:0]           velocity_abs,
   // brake circuit pins
   input  wire mba_pkg::mba_brk_pin_t brake_pins,
   output      logic                  brake_release,
   output      logic [2:0]            brake_fault
);

   mba_pkg::mba_state_t st_r;   // registered state
   mba_pkg::mba_state_t st_nxt; // next state

   // parameter index of a motor slot
   function automatic logic [15:0] slot_idx(input logic [4:0] s);
      if (s == mba_pkg::SLOT_BRAKE) begin
         return mba_pkg::IDX_BRAKE;
      end else if (s == mba_pkg::SLOT_COIL_TC) begin
         return mba_pkg::IDX_COIL_TC;
      end else if (s == mba_pkg::SLOT_CONT_CUR) begin
         return mba_pkg::IDX_CONT_CUR;
      end
      return mba_pkg::IDX_MEM_BASE + {11'h000, s};
   endfunction : slot_idx

   // decode an index to {hit, slot}; read and write both use it
   function automatic logic [5:0] slot_hit(input logic [15:0] idx);
      logic [5:0] r;
      r = 6'h00;
      for (int s = 0; s < mba_pkg::NSLOT; s++) begin
         if (idx == slot_idx(5'(s))) begin
            r = {1'b1, 5'(s)};
         end
      end
      return r;
   endfunction : slot_hit

   // may memory fill this slot under current version and firmware
   function automatic logic slot_fillable(input logic [4:0] s, input logic [15:0] ver);
      if (s < mba_pkg::SLOT_EXT_FIRST) begin
         return 1'b1;
      end else if (s < mba_pkg::SLOT_FW_FIRST) begin
         return ver > mba_pkg::MEMVER_MIN;
      end else if (s <= mba_pkg::SLOT_LAST) begin
         return FW_VERSION >= mba_pkg::FW_TEMP_MIN;
      end
      return 1'b0;
   endfunction : slot_fillable

   // decoded host access, brake poll and millisecond ticks, standstill
   logic [5:0]  wr_hit;      // slot decode of the request index
   logic        wr_slot_ok;  // slot write not locked
   logic        poll_tick;   // brake poll instant
   logic        ms_tick;     // one millisecond elapsed
   logic        stand_still; // velocity under threshold
   logic [31:0] status_word; // read value of the status index

   assign wr_hit      = slot_hit(host_req.idx);
   // locked only while auto mode holds and memory filled the slot
   assign wr_slot_ok  = !(st_r.auto_cfg && st_r.loaded[wr_hit[4:0]]);
   assign poll_tick   = (st_r.poll_cnt == POLL_CYCLES - 1'b1);
   assign ms_tick     = (st_r.ms_cnt == MS_CYCLES - 1'b1);
   assign stand_still = (velocity_abs < st_r.vthresh);

   // status layout: latched faults low, brake output state above
   always_comb begin
      status_word                        = 32'h0000_0000;
      status_word[mba_pkg::ST_F_ABSENT:0] = st_r.fault;
      status_word[mba_pkg::ST_RELEASE]   = st_r.release_brk;
   end

   // next-state logic for the whole block
   always_comb begin
      st_nxt = st_r;

      // pins pass two flip-flops; only sync2 is looked at
      st_nxt.sync1 = brake_pins;
      st_nxt.sync2 = st_r.sync1;

      // answer is a one-cycle pulse after each request
      st_nxt.rsp.ack   = 1'b0;
      st_nxt.rsp.err   = 1'b0;
      st_nxt.rsp.rdata = 32'h0000_0000;

      // host writes
      if (host_req.wr) begin
         st_nxt.rsp.ack = 1'b1;
         if (wr_hit[5]) begin
            if (wr_slot_ok) begin
               st_nxt.prm[wr_hit[4:0]] = host_req.wdata;
            end else begin
               st_nxt.rsp.err = 1'b1;
            end
         end else begin
            unique case (host_req.idx)
               mba_pkg::IDX_AUTO_CFG: begin
                  st_nxt.auto_cfg = host_req.wdata[0];
                  // leaving auto mode frees every slot it filled
                  if (!host_req.wdata[0]) begin
                     st_nxt.loaded = '0;
                  end
               end
               mba_pkg::IDX_LOAD_INER: begin
                  // positive floats order like their bit patterns
                  if (!host_req.wdata[31] &&
                      host_req.wdata >= mba_pkg::INER_MIN &&
                      host_req.wdata <= mba_pkg::INER_MAX) begin
                     st_nxt.load_iner = host_req.wdata;
                  end else begin
                     st_nxt.rsp.err = 1'b1;
                  end
               end
               mba_pkg::IDX_BRAKE_IMM: begin
                  st_nxt.brake_imm = host_req.wdata[0];
               end
               mba_pkg::IDX_VTHRESH: begin
                  st_nxt.vthresh = host_req.wdata;
               end
               mba_pkg::IDX_DWELL: begin
                  st_nxt.dwell = host_req.wdata[15:0];
               end
               mba_pkg::IDX_FAULT_CLR: begin
                  st_nxt.fault = st_r.fault & ~host_req.wdata[2:0];
               end
               default: begin
                  // status is read-only, anything else is unmapped
                  st_nxt.rsp.err = 1'b1;
               end
            endcase
         end
      end else if (host_req.rd) begin
         // host reads
         st_nxt.rsp.ack = 1'b1;
         if (wr_hit[5]) begin
            st_nxt.rsp.rdata = st_r.prm[wr_hit[4:0]];
         end else begin
            unique case (host_req.idx)
               mba_pkg::IDX_AUTO_CFG: begin
                  st_nxt.rsp.rdata = {31'h0000_0000, st_r.auto_cfg};
               end
               mba_pkg::IDX_LOAD_INER: begin
                  st_nxt.rsp.rdata = st_r.load_iner;
               end
               mba_pkg::IDX_BRAKE_IMM: begin
                  st_nxt.rsp.rdata = {31'h0000_0000, st_r.brake_imm};
               end
               mba_pkg::IDX_VTHRESH: begin
                  st_nxt.rsp.rdata = st_r.vthresh;
               end
               mba_pkg::IDX_DWELL: begin
                  st_nxt.rsp.rdata = {16'h0000, st_r.dwell};
               end
               mba_pkg::IDX_STATUS: begin
                  st_nxt.rsp.rdata = status_word;
               end
               mba_pkg::IDX_FAULT_CLR: begin
                  st_nxt.rsp.rdata = 32'h0000_0000;
               end
               default: begin
                  st_nxt.rsp.err = 1'b1;
               end
            endcase
         end
      end

      // memory fill; runs after the host write so it wins a collision
      if (mem_word.valid && st_r.auto_cfg &&
          slot_fillable(mem_word.slot, mem_word.version)) begin
         st_nxt.prm[mem_word.slot]    = mem_word.data;
         st_nxt.loaded[mem_word.slot] = 1'b1;
      end

      // poll counter, free running
      if (poll_tick) begin
         st_nxt.poll_cnt = '0;
      end else begin
         st_nxt.poll_cnt = st_r.poll_cnt + 1'b1;
      end

      // circuit checks only at poll instants and only with a brake;
      // placed after the clear so a new fault survives a same-cycle clear
      if (poll_tick && st_r.prm[mba_pkg::SLOT_BRAKE][0]) begin
         if (st_r.sync2.open_ckt) begin
            st_nxt.fault[mba_pkg::ST_F_OPEN] = 1'b1;
         end
         if (st_r.sync2.short_ckt) begin
            st_nxt.fault[mba_pkg::ST_F_SHORT] = 1'b1;
         end
         if (!st_r.sync2.connected) begin
            st_nxt.fault[mba_pkg::ST_F_ABSENT] = 1'b1;
         end
      end

      // millisecond base, restarted on each disable so the dwell is whole
      if (ms_tick || st_r.bst != mba_pkg::BS_WAIT) begin
         st_nxt.ms_cnt = '0;
      end else begin
         st_nxt.ms_cnt = st_r.ms_cnt + 1'b1;
      end

      // brake sequencer; brake_present takes no part here
      unique case (st_r.bst)
         mba_pkg::BS_RUN: begin
            st_nxt.release_brk = 1'b1;
            if (!drive_enable) begin
               if (st_r.brake_imm) begin
                  st_nxt.bst         = mba_pkg::BS_HELD;
                  st_nxt.release_brk = 1'b0;
               end else begin
                  st_nxt.bst       = mba_pkg::BS_WAIT;
                  st_nxt.dwell_cnt = 16'h0000;
               end
            end
         end
         mba_pkg::BS_WAIT: begin
            // brake stays released while the axis coasts down
            st_nxt.release_brk = 1'b1;
            if (drive_enable) begin
               st_nxt.bst = mba_pkg::BS_RUN;
            end else if (st_r.brake_imm) begin
               // immediate mode switched on mid-wait: apply now
               st_nxt.bst         = mba_pkg::BS_HELD;
               st_nxt.release_brk = 1'b0;
            end else if (!stand_still) begin
               st_nxt.dwell_cnt = 16'h0000;
            end else if (st_r.dwell_cnt >= st_r.dwell) begin
               st_nxt.bst         = mba_pkg::BS_HELD;
               st_nxt.release_brk = 1'b0;
            end else if (ms_tick) begin
               st_nxt.dwell_cnt = st_r.dwell_cnt + 1'b1;
            end
         end
         mba_pkg::BS_HELD: begin
            st_nxt.release_brk = 1'b0;
            if (drive_enable) begin
               st_nxt.bst         = mba_pkg::BS_RUN;
               st_nxt.release_brk = 1'b1;
            end
         end
         default: begin
            // illegal one-hot code: fail safe with brake applied
            st_nxt.bst         = mba_pkg::BS_HELD;
            st_nxt.release_brk = 1'b0;
         end
      endcase
   end

   // one register for all state; brake applied and nothing loaded at reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r           <= '0;
         st_r.vthresh   <= mba_pkg::RST_WORD;
         st_r.dwell     <= mba_pkg::RST_DWELL;
         st_r.load_iner <= mba_pkg::RST_WORD;
         st_r.bst       <= mba_pkg::BS_HELD;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flip-flops
   assign host_rsp      = st_r.rsp;
   assign brake_release = st_r.release_brk;
   assign brake_fault   = st_r.fault;

endmodule : mba_top

// >>> sim/mba_props.sv
// checker of host answers, brake poll timing and brake sequencer
`timescale 1ns/100ps
module mba_props #(
   parameter logic [mba_pkg::CNT_W-1:0] POLL_CYCLES = mba_pkg::CNT_W'(mba_pkg::POLL_CYC)
) (
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  reset_n,
   // host parameter port
   input wire mba_pkg::mba_req_t     host_req,
   input wire mba_pkg::mba_rsp_t     host_rsp,
   // feedback memory and drive state
   input wire mba_pkg::mba_mem_t     mem_word,
   input wire logic                  drive_enable,
   input wire logic [31:0]           velocity_abs,
   // brake circuit
   input wire mba_pkg::mba_brk_pin_t brake_pins,
   input wire logic                  brake_release,
   input wire logic [2:0]            brake_fault
);
   logic [mba_pkg::CNT_W-1:0] pc_r;     // poll phase, zero just after a poll edge
   logic                      wb_r;     // pending brake presence write
   logic                      wa_r;     // pending auto-configuration write
   logic                      wi_r;     // pending immediate-brake write
   logic                      wd_r;     // pending write bit
   logic                      brk_r;    // mirrors lag the design by one cycle
   logic                      auto_r;
   logic                      imm_r;
   logic [2:0]                fprev_r;  // fault bits one cycle back
   mba_pkg::mba_mem_t         md_r;     // memory word one cycle back
   logic [2:0]                newf;     // fault bits that just rose

   assign newf = brake_fault & ~fprev_r;

   // mirror settings only once the answer shows the write was accepted
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_r    <= '0;
         {wb_r, wa_r, wi_r, wd_r, brk_r, auto_r, imm_r} <= '0;
         fprev_r <= '0;
         md_r    <= '0;
      end else begin
         pc_r    <= (pc_r == POLL_CYCLES - 1'b1) ? '0 : pc_r + 1'b1;
         wb_r    <= host_req.wr && host_req.idx == mba_pkg::IDX_BRAKE;
         wa_r    <= host_req.wr && host_req.idx == mba_pkg::IDX_AUTO_CFG;
         wi_r    <= host_req.wr && host_req.idx == mba_pkg::IDX_BRAKE_IMM;
         wd_r    <= host_req.wdata[0];
         md_r    <= mem_word;
         fprev_r <= brake_fault;
         if (host_rsp.ack && !host_rsp.err && wa_r) auto_r <= wd_r;
         if (host_rsp.ack && !host_rsp.err && wi_r) imm_r <= wd_r;
         // a memory fill wins over a host write in the same cycle
         if (md_r.valid && md_r.slot == mba_pkg::SLOT_BRAKE && auto_r) brk_r <= md_r.data[0];
         else if (host_rsp.ack && !host_rsp.err && wb_r) brk_r <= wd_r;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_ACK_NEXT: assert property ((host_req.wr || host_req.rd) |=> host_rsp.ack)
      else $error("no answer one cycle after a host request");
   AST_INER_RANGE: assert property ((host_req.wr && host_req.idx == mba_pkg::IDX_LOAD_INER
      && (host_req.wdata < mba_pkg::INER_MIN || host_req.wdata > mba_pkg::INER_MAX))
      |=> host_rsp.ack && host_rsp.err) else $error("inertia out of range accepted");
   AST_POLL_ONLY: assert property ((|newf) |-> pc_r == '0)
      else $error("brake fault raised away from a poll instant");
   AST_ABSENT_QUIET: assert property ((|newf) |-> brk_r)
      else $error("brake fault raised with no brake present");
   AST_FAULT_HOLD: assert property ((|(fprev_r & ~brake_fault)) |->
      $past(host_req.wr) && $past(host_req.idx) == mba_pkg::IDX_FAULT_CLR)
      else $error("brake fault dropped without a clear");
   AST_IMM_APPLY: assert property (($fell(drive_enable) && imm_r) |=> !brake_release)
      else $error("brake not applied at once on disable");
   AST_ENABLE_RLS: assert property (drive_enable |=> brake_release)
      else $error("brake not released while enabled");
   AST_APPLY_CAUSE: assert property ($fell(brake_release) |-> !$past(drive_enable))
      else $error("brake applied while drive enabled");
   AST_FLAG_NO_DRIVE: assert property ((host_req.wr && host_req.idx == mba_pkg::IDX_BRAKE
      && !drive_enable && !brake_release) |=> !brake_release)
      else $error("brake presence write released the brake");

   cover property ($fell(drive_enable) && imm_r);
   cover property (|newf);
   cover property (host_rsp.ack && host_rsp.err);
endmodule : mba_props

bind mba_top mba_props #(.POLL_CYCLES(POLL_CYCLES)) u_props (
   .ref_clk(ref_clk), .reset_n(reset_n), .host_req(host_req), .host_rsp(host_rsp),
   .mem_word(mem_word), .drive_enable(drive_enable), .velocity_abs(velocity_abs),
   .brake_pins(brake_pins), .brake_release(brake_release), .brake_fault(brake_fault));

// >>> sim/mba_motor_model.sv
// far side: feedback memory reader and brake circuit pins
`timescale 1ns/100ps
module mba_motor_model (
   // clock
   input wire logic              ref_clk,
   // identification words and brake indications
   output mba_pkg::mba_mem_t     mem_word,
   output mba_pkg::mba_brk_pin_t brake_pins
);
   // idle: no word, brake connected and healthy
   initial begin
      mem_word   = '0;
      brake_pins = 3'b001;
   end

   // one word per slot; lines then show the inverse so stale data never looks valid
   task automatic fill(input logic [4:0] s, input logic [31:0] d, input logic [15:0] v);
      @(posedge ref_clk);
      mem_word <= '{valid: 1'b1, slot: s, data: d, version: v};
      @(posedge ref_clk);
      mem_word <= '{valid: 1'b0, slot: ~s, data: ~d, version: ~v};
   endtask : fill

   // open, short and connection indications change at an edge
   task automatic pins(input mba_pkg::mba_brk_pin_t p);
      @(posedge ref_clk);
      brake_pins <= p;
   endtask : pins
endmodule : mba_motor_model

// >>> sim/mba_top_test.sv
// self-checking bench of the motor brake / auto-configuration block
`timescale 1ns/100ps
module mba_top_test;
   logic                  ref_clk;       // 20 MHz
   logic                  reset_n;       // async, active low
   mba_pkg::mba_req_t     host_req;
   mba_pkg::mba_rsp_t     host_rsp;
   mba_pkg::mba_mem_t     mem_word;
   mba_pkg::mba_brk_pin_t brake_pins;
   logic                  drive_enable;
   logic [31:0]           velocity_abs;
   logic                  brake_release;
   logic [2:0]            brake_fault;
   int                    error_cnt;
   int                    checks;
   int                    auto_m;        // model of auto-configuration
   logic [31:0]           val_m [int];   // model values by index
   bit                    lock_m [int];  // memory-filled indices
   logic [31:0]           iner [6] = '{32'h3f7f_ffff, 32'h3f80_0000, 32'h4974_2400,
                                       32'h4974_2401, 32'hbf80_0000, 32'h4000_0000};
   mba_pkg::mba_brk_pin_t pat [3] = '{3'b101, 3'b011, 3'b000};

   // short poll and millisecond so the run stays brief
   mba_top #(.POLL_CYCLES(24'h40), .MS_CYCLES(24'h8), .FW_VERSION(mba_pkg::FW_TEMP_MIN)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .host_req(host_req), .host_rsp(host_rsp),
      .mem_word(mem_word), .drive_enable(drive_enable), .velocity_abs(velocity_abs),
      .brake_pins(brake_pins), .brake_release(brake_release), .brake_fault(brake_fault));
   mba_motor_model mdl (.ref_clk(ref_clk), .mem_word(mem_word), .brake_pins(brake_pins));

   always #25 ref_clk = ~ref_clk;

   function automatic int slot_idx(int s);
      return s == 0 ? mba_pkg::IDX_BRAKE : s == 1 ? mba_pkg::IDX_COIL_TC :
             s == 2 ? mba_pkg::IDX_CONT_CUR : mba_pkg::IDX_MEM_BASE + s;
   endfunction : slot_idx

   // model write: locked, out of range or unmapped is refused
   function automatic bit m_write(int idx, logic [31:0] wd);
      if (lock_m.exists(idx) && auto_m == 1) return 1'b1;
      if (idx == mba_pkg::IDX_LOAD_INER && (wd < mba_pkg::INER_MIN || wd > mba_pkg::INER_MAX))
         return 1'b1;
      // fault clear is write-only and always taken, so it never answers an error
      if (idx == mba_pkg::IDX_FAULT_CLR) return 1'b0;
      if (!val_m.exists(idx)) return 1'b1;
      if (idx == mba_pkg::IDX_AUTO_CFG && wd[0] == 1'b0) lock_m.delete();
      if (idx == mba_pkg::IDX_AUTO_CFG) auto_m = wd[0];
      val_m[idx] = wd;
      return 1'b0;
   endfunction : m_write

   task automatic chk_rsp(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t answer got %h exp %h", $time, got, exp);
      end
   endtask : chk_rsp

   task automatic chk_brk(input logic [3:0] exp);
      checks++;
      if ({brake_release, brake_fault} !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t brake got %h exp %h", $time, {brake_release, brake_fault}, exp);
      end
   endtask : chk_brk

   // one request, held for its taking edge, answer looked at in its cycle
   task automatic host(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      logic        ee;
      logic [31:0] ed;
      ee = wr ? m_write(idx, wd) : !val_m.exists(idx);
      ed = (wr || ee) ? 32'h0 : val_m[idx];
      @(posedge ref_clk);
      host_req <= '{wr: wr, rd: ~wr, idx: idx, wdata: wd};
      @(posedge ref_clk);
      host_req <= '0;
      #1;
      chk_rsp({host_rsp.ack, host_rsp.err, wr ? 32'h0 : host_rsp.rdata}, {1'b1, ee, ed});
   endtask : host

   task automatic fill(input int s, input logic [15:0] v);
      logic [31:0] d;
      d = (s == 0) ? 32'h0 : $urandom;
      if (auto_m == 1 && (s <= 10 || s >= 15 || v > 16'h0001)) begin
         val_m[slot_idx(s)] = d;
         lock_m[slot_idx(s)] = 1'b1;
      end
      mdl.fill(s[4:0], d, v);
   endtask : fill

   task automatic sweep();
      int idx;
      for (int s = 0; s < mba_pkg::NSLOT; s++) begin
         idx = slot_idx(s);
         host(1'b0, idx[15:0], 32'h0);
         host(1'b1, idx[15:0], (s == 0) ? 32'h0 : $urandom);
         host(1'b0, idx[15:0], 32'h0);
      end
   endtask : sweep

   task automatic print_verdict();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   // watchdog well beyond the expected run length
   initial begin
      #(50 * 20000);
      error_cnt++;
      print_verdict();
   end

   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      host_req = '0;
      drive_enable = 1'b0;
      velocity_abs = 32'h0;
      {error_cnt, checks, auto_m} = '0;
      void'($urandom(32'h53ae));
      for (int s = 0; s < mba_pkg::NSLOT; s++) val_m[slot_idx(s)] = 32'h0;
      val_m[mba_pkg::IDX_AUTO_CFG] = 32'h0;
      val_m[mba_pkg::IDX_LOAD_INER] = 32'h0;
      val_m[mba_pkg::IDX_BRAKE_IMM] = 32'h0;
      val_m[mba_pkg::IDX_VTHRESH] = 32'h0;
      val_m[mba_pkg::IDX_DWELL] = 32'h0;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      foreach (val_m[k]) host(1'b0, k[15:0], 32'h0);
      host(1'b0, 16'h3800, 32'h0);
      host(1'b1, mba_pkg::IDX_STATUS, 32'h1);
      // manual mode: memory words ignored, host owns the values
      for (int s = 3; s < 6; s++) fill(s, 16'h0002);
      sweep();
      // auto mode at version 0.01, then above it
      host(1'b1, mba_pkg::IDX_AUTO_CFG, 32'h1);
      for (int s = 0; s < mba_pkg::NSLOT; s++) fill(s, 16'h0001);
      sweep();
      for (int s = 11; s < 15; s++) fill(s, 16'h0002);
      sweep();
      foreach (iner[i]) host(1'b1, mba_pkg::IDX_LOAD_INER, iner[i]);
      host(1'b0, mba_pkg::IDX_LOAD_INER, 32'h0);
      host(1'b1, mba_pkg::IDX_AUTO_CFG, 32'h0);
      sweep();
      // brake absent: indications ignored; present: each latched until cleared
      host(1'b1, mba_pkg::IDX_BRAKE, 32'h0);
      mdl.pins(pat[0]);
      repeat (200) @(posedge ref_clk);
      chk_brk(4'h0);
      host(1'b1, mba_pkg::IDX_BRAKE, 32'h1);
      for (int k = 0; k < 3; k++) begin
         mdl.pins(pat[k]);
         repeat (200) @(posedge ref_clk);
         chk_brk(4'(1 << k));
         mdl.pins(3'b001);
         repeat (200) @(posedge ref_clk);
         chk_brk(4'(1 << k));
         // status shows the latched fault with the brake still applied
         val_m[mba_pkg::IDX_STATUS] = 32'(1 << k);
         host(1'b0, mba_pkg::IDX_STATUS, 32'h0);
         host(1'b1, mba_pkg::IDX_FAULT_CLR, 32'h7);
         chk_brk(4'h0);
      end
      // disable with immediate braking, then with the standstill dwell
      host(1'b1, mba_pkg::IDX_VTHRESH, 32'd100);
      host(1'b1, mba_pkg::IDX_DWELL, 32'd3);
      for (int m = 1; m >= 0; m--) begin
         host(1'b1, mba_pkg::IDX_BRAKE_IMM, 32'(m));
         velocity_abs <= 32'd100 + $urandom_range(0, 1000);
         drive_enable <= 1'b1;
         repeat (4) @(posedge ref_clk);
         chk_brk(4'h8);
         drive_enable <= 1'b0;
         repeat (2) @(posedge ref_clk);
         #1;
         chk_brk({~m[0], 3'b000});
         @(posedge ref_clk);
         velocity_abs <= $urandom_range(0, 99);
         repeat (8) @(posedge ref_clk);
         chk_brk({~m[0], 3'b000});
         repeat (40) @(posedge ref_clk);
         chk_brk(4'h0);
      end
      print_verdict();
   end
endmodule : mba_top_test
